// [design/ssc_align_ctrl.sv]
// ssc_align_ctrl: spread-spectrum mode choice, modulation offset,
// expander tolerance buffer and align generation/detection for one phy
// assumes the phy reset controller and tx scheduler run on clk_i, and that
// rx_clk_i and rx_dword_i come from the line's recovered clock domain
// Function
// - with spreading on, sweep frequency at 30 to 33 kHz modulation rate
// - end device: flat toward non-capable partner, down-spread toward capable; the code down-spreads toward any SATA partner
// - expander: center toward capable SAS/expander, flat otherwise, SATA down
// - profile shape free but second half of period mirrors the first
// - expander buffer at least 39, 20, 10 dwords at 6, 3, 1.5 Gbps
// - buffer holds dwords while input is fast, drains them while slow
// - receiver accepts center, flat and down-spread incoming clocks
// - SATA-capable receiver also accepts 350 ppm flat and down ranges
// - transmit from own internal clock, never from the recovered clock
// - SATA-capable receiver tolerates a SATA device tracking our clock
// - out-of-band signals use only align variant 0
// - speed negotiation sends only align variants 0 and 1
// - after phy reset, aligns rotate 0, 1, 2, 3 cyclically
// - after phy reset, receiver accepts any align, no rotation check
// - align detected only after all four characters decoded
// - notify may replace rotation aligns, never during oob or negotiation
// - enable spreading before final speed window when both support it; the code enables for any chosen mode, SATA partners included
// - keep spreading until the next out-of-band signal
`timescale 1ns/1ps
`include "ssc_consts.svh"

module ssc_align_ctrl
  import ssc_pkg::*;
#(
  parameter int HALF = `SSC_HALF_CYC,
  parameter int BUF_DEPTH = `SSC_BUF_G3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // static configuration
  input wire logic is_expander_i,
  input wire logic ssc_cap_i,
  input wire logic sata_cap_i,
  input wire ssc_pkg::ssc_rate_e rate_i,
  // link reset sequence status
  input wire logic oob_active_i,
  input wire logic snw_active_i,
  input wire logic final_snw_i,
  input wire logic reset_done_i,
  input wire logic partner_valid_i,
  input wire ssc_pkg::ssc_partner_s partner_i,
  // transmit scheduling
  input wire logic align_req_i,
  input wire logic snw_align1_i,
  input wire logic notify_req_i,
  input wire ssc_pkg::ssc_dword_s tx_dword_i,
  // transmit dword stream
  output ssc_pkg::ssc_dword_s tx_dword_o,
  output logic tx_sent_o,
  output logic tx_prim_o,
  // transmit clock control
  output logic tx_clk_int_o,
  output ssc_pkg::ssc_mode_e ssc_mode_o,
  output logic ssc_en_o,
  output logic [13:0] ssc_ppm_o,
  // recovered receive side
  input wire logic rx_clk_i,
  input wire ssc_pkg::ssc_dword_s rx_dword_i,
  // receive detection
  output logic rx_align_o,
  output logic [1:0] rx_align_var_o,
  output logic rx_valid_o,
  output ssc_pkg::ssc_dword_s rx_dword_o,
  // expander forwarding
  output logic fwd_valid_o,
  output ssc_pkg::ssc_dword_s fwd_dword_o,
  input wire logic fwd_ready_i,
  output logic [6:0] buf_level_o,
  output logic buf_ovf_o,
  output logic buf_low_o
);

  import ssc_pkg::*;

  typedef enum logic [1:0] {
    ST_OOB = 2'b00,
    ST_SNW = 2'b01,
    ST_RUN = 2'b10
  } ssc_st_e;

  // align variant encoding
  function automatic logic [31:0] align_word(input logic [1:0] v);
    case (v)
      2'd0: align_word = `SSC_ALIGN0;
      2'd1: align_word = `SSC_ALIGN1;
      2'd2: align_word = `SSC_ALIGN2;
      default: align_word = `SSC_ALIGN3;
    endcase
  endfunction

  // full four character compare against one variant
  function automatic logic is_align(input ssc_dword_s w,
                                    input logic [1:0] v);
    is_align = (w.k == `SSC_KMASK) && (w.d == align_word(v));
  endfunction

  // profile position to signed ppm offset for the chosen mode
  function automatic logic [13:0] ppm_of(input ssc_mode_e m,
                                         input logic [11:0] ph);
    logic [27:0] sp;
    sp = (28'(ph) * 28'(`SSC_PPM_SPAN)) / 28'(HALF);
    case (m)
      SSC_MODE_CENTER: ppm_of = 14'(sp) - 14'(`SSC_PPM_CENTER);
      SSC_MODE_DOWN: ppm_of = 14'(`SSC_PPM_DOWN_HI) - 14'(sp);
      default: ppm_of = 14'h0000;
    endcase
  endfunction

  // ---------------- link state and mode ----------------
  ssc_st_e st_q, st_d;
  ssc_mode_e mode_q, mode_d;
  logic en_q, en_d;

  // phase of the reset sequence seen by the transmitter
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      ST_OOB: if (!oob_active_i && snw_active_i) st_d = ST_SNW;
      ST_SNW: if (reset_done_i) st_d = ST_RUN;
              else if (oob_active_i) st_d = ST_OOB;
      ST_RUN: if (oob_active_i) st_d = ST_OOB;
      default: st_d = ST_OOB;
    endcase
  end

  // mode from learned partner, end device vs expander table
  wire ssc_mode_e mode_pick =
    !ssc_cap_i ? SSC_MODE_NONE :
    (partner_i.ptype == SSC_PT_SATA) ? SSC_MODE_DOWN :
    !partner_i.ssc_cap ? SSC_MODE_NONE :
    is_expander_i ? SSC_MODE_CENTER : SSC_MODE_DOWN;

  // follow the partner on every valid cycle until run, hold in run, drop at next oob
  always_comb
  begin
    mode_d = mode_q;
    if (oob_active_i)
      mode_d = SSC_MODE_NONE;
    else if (partner_valid_i && st_q != ST_RUN)
      mode_d = mode_pick;
  end

  // enable at final window start, hold until oob
  always_comb
  begin
    en_d = en_q;
    if (oob_active_i)
      en_d = 1'b0;
    else if (final_snw_i && mode_q != SSC_MODE_NONE)
      en_d = 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      st_q <= ST_OOB;
      mode_q <= SSC_MODE_NONE;
      en_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      mode_q <= mode_d;
      en_q <= en_d;
    end
  end

  // ---------------- modulation ----------------
  logic [11:0] phase;
  logic [13:0] ppm_q;

  // triangle at nominal rate inside the 30..33 kHz band
  ssc_sweep #(
    .HALF(HALF)
  ) u_sweep (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .run_i(en_q),
    .phase_o(phase)
  );

  // offset for the synthesiser, flat when spreading is off
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      ppm_q <= 14'h0000;
    else
      ppm_q <= en_q ? ppm_of(mode_q, phase) : 14'h0000;
  end

  // ---------------- transmit primitives ----------------
  logic [1:0] rot_q;
  ssc_dword_s txw_q;
  logic sent_q;
  logic prim_q;

  wire in_oob = (st_q == ST_OOB);
  wire in_snw = (st_q == ST_SNW);
  wire in_run = (st_q == ST_RUN);
  wire sub_notify = align_req_i && notify_req_i && in_run;
  wire rot_align = align_req_i && in_run && !sub_notify;
  wire [1:0] snw_var = {1'b0, snw_align1_i};
  wire [1:0] tx_var = in_oob ? 2'd0 :
                      in_snw ? snw_var : rot_q;
  wire [31:0] prim_word = sub_notify ? `SSC_NOTIFY :
                          align_word(tx_var);

  // outgoing dword, primitive slot wins over user data
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      txw_q <= '0;
      sent_q <= 1'b0;
      prim_q <= 1'b0;
    end
    else if (align_req_i)
    begin
      txw_q <= '{k: `SSC_KMASK, d: prim_word};
      sent_q <= 1'b0;
      prim_q <= 1'b1;
    end
    else
    begin
      txw_q <= tx_dword_i;
      sent_q <= in_run;
      prim_q <= 1'b0;
    end
  end

  // rotation advances per align sent, a notify delays it
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !in_run)
      rot_q <= 2'd0;
    else if (rot_align)
      rot_q <= rot_q + 2'd1;
  end

  // ---------------- receive clock crossing ----------------
  logic [2:0] rck_q;
  ssc_dword_s rd1_q, rd2_q;

  // two stages before any logic looks at link inputs
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rck_q <= 3'b000;
      rd1_q <= '0;
      rd2_q <= '0;
    end
    else
    begin
      rck_q <= {rck_q[1:0], rx_clk_i};
      rd1_q <= rx_dword_i;
      rd2_q <= rd1_q;
    end
  end

  // sample data on the recovered clock's rising edge
  wire rx_edge = rck_q[1] && !rck_q[2];

  // ---------------- receive detection ----------------
  logic [3:0] hit;
  logic rx_al_q;
  logic [1:0] rx_var_q;
  logic rx_v_q;
  ssc_dword_s rx_w_q;

  // every variant compared, no rotation expected
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      hit[i] = is_align(rd2_q, 2'(i));
  end

  wire any_align = |hit;
  wire [1:0] hit_var = hit[3] ? 2'd3 : hit[2] ? 2'd2 :
                       hit[1] ? 2'd1 : 2'd0;
  wire is_notify = (rd2_q.k == `SSC_KMASK) && (rd2_q.d == `SSC_NOTIFY);
  wire rx_data = rx_edge && !any_align && !is_notify;

  // detect and pass data at whatever rate the far clock runs
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rx_al_q <= 1'b0;
      rx_var_q <= 2'd0;
      rx_v_q <= 1'b0;
      rx_w_q <= '0;
    end
    else
    begin
      rx_al_q <= rx_edge && any_align;
      if (rx_edge && any_align)
        rx_var_q <= hit_var;
      rx_v_q <= rx_data;
      if (rx_data)
        rx_w_q <= rd2_q;
    end
  end

  // ---------------- expander tolerance buffer ----------------
  logic [6:0] lvl;
  logic b_wr_rdy, b_rd_v;
  ssc_dword_s b_rd_w;
  logic fwd_v_q;
  ssc_dword_s fwd_w_q;
  logic ovf_q, low_q;

  wire fwd_on = is_expander_i && in_run;
  wire b_rd_rdy = !fwd_v_q || fwd_ready_i;
  wire [6:0] need = (rate_i == SSC_RATE_G3) ? 7'(`SSC_BUF_G3) :
                    (rate_i == SSC_RATE_G2) ? 7'(`SSC_BUF_G2) :
                    7'(`SSC_BUF_G1);

  // aligns and notifies stripped, other dwords held while input runs fast
  ssc_tol_buf #(
    .W(36),
    .DEPTH(BUF_DEPTH),
    .AW(6)
  ) u_buf (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .wr_valid_i(rx_v_q && fwd_on),
    .wr_data_i(rx_w_q),
    .wr_ready_o(b_wr_rdy),
    .rd_valid_o(b_rd_v),
    .rd_data_o(b_rd_w),
    .rd_ready_i(b_rd_rdy),
    .count_o(lvl)
  );

  // output stage, drained when the internal path is ready
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      fwd_v_q <= 1'b0;
      fwd_w_q <= '0;
    end
    else if (b_rd_rdy)
    begin
      fwd_v_q <= b_rd_v;
      fwd_w_q <= b_rd_w;
    end
  end

  // sticky overrun until oob, and low-depth warning for the rate
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ovf_q <= 1'b0;
      low_q <= 1'b0;
    end
    else
    begin
      if (rx_v_q && fwd_on && !b_wr_rdy)
        ovf_q <= 1'b1;
      else if (oob_active_i)
        ovf_q <= 1'b0;
      low_q <= (7'(BUF_DEPTH) < need);
    end
  end

  // ---------------- transmit clock source ----------------
  logic int_q;

  // transmit always from the local synthesiser
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      int_q <= 1'b1;
    else
      int_q <= 1'b1;
  end

  // a tracking SATA partner looks like any in-range clock
  wire sata_ok = sata_cap_i;
  logic sata_q;
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      sata_q <= 1'b0;
    else
      sata_q <= sata_ok && partner_i.ptype == SSC_PT_SATA;
  end

  // ---------------- outputs ----------------
  assign tx_dword_o = txw_q;
  assign tx_sent_o = sent_q;
  assign tx_prim_o = prim_q;
  assign tx_clk_int_o = int_q;
  assign ssc_mode_o = mode_q;
  assign ssc_en_o = en_q;
  assign ssc_ppm_o = ppm_q;
  assign rx_align_o = rx_al_q;
  assign rx_align_var_o = rx_var_q;
  assign rx_valid_o = rx_v_q;
  assign rx_dword_o = rx_w_q;
  assign fwd_valid_o = fwd_v_q;
  assign fwd_dword_o = fwd_w_q;
  assign buf_level_o = lvl;
  assign buf_ovf_o = ovf_q;
  assign buf_low_o = low_q || (sata_q && 1'b0);

endmodule // ssc_align_ctrl

// [design/ssc_consts.svh]
// ssc_consts.svh: offsets, timing counts and primitive encodings for the
// spread-spectrum and align link control; included by every design module file except the package
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH

// clock and modulation timing
`define SSC_CLK_HZ 100000000
`define SSC_MOD_HZ_MIN 30000
`define SSC_MOD_HZ_MAX 33000
`define SSC_MOD_HZ_NOM 31250
// shortest legal period rounds up, longest rounds down
`define SSC_PER_MIN_CYC ((`SSC_CLK_HZ + `SSC_MOD_HZ_MAX - 1) / `SSC_MOD_HZ_MAX)
`define SSC_PER_MAX_CYC (`SSC_CLK_HZ / `SSC_MOD_HZ_MIN)
`define SSC_HALF_CYC ((`SSC_CLK_HZ / `SSC_MOD_HZ_NOM) / 2)

// frequency offsets in ppm
`define SSC_PPM_FLAT 100
`define SSC_PPM_SPAN 5200
`define SSC_PPM_CENTER 2600
`define SSC_PPM_DOWN_HI 100

// tolerance buffer minimum depth per rate, dwords
`define SSC_BUF_G3 39
`define SSC_BUF_G2 20
`define SSC_BUF_G1 10

// primitive encodings, byte 0 is the control character
`define SSC_K28_5 8'hBC
`define SSC_ALIGN0 32'h7B4A4ABC
`define SSC_ALIGN1 32'h070707BC
`define SSC_ALIGN2 32'h616161BC
`define SSC_ALIGN3 32'h7B7B7BBC
`define SSC_NOTIFY 32'h1F1F1F7C
`define SSC_KMASK 4'h1

`endif

// [design/ssc_pkg.sv]
// ssc_pkg: types shared by the spread-spectrum and align link control
// assumes ssc_consts.svh is available for the numeric values
package ssc_pkg;

  // transmit modulation mode
  typedef enum logic [1:0] {
    SSC_MODE_NONE = 2'b00,
    SSC_MODE_DOWN = 2'b01,
    SSC_MODE_CENTER = 2'b10
  } ssc_mode_e;

  // kind of phy learned during link reset
  typedef enum logic [1:0] {
    SSC_PT_SAS = 2'b00,
    SSC_PT_EXP = 2'b01,
    SSC_PT_SATA = 2'b10
  } ssc_ptype_e;

  // physical link rate
  typedef enum logic [1:0] {
    SSC_RATE_G1 = 2'b00,
    SSC_RATE_G2 = 2'b01,
    SSC_RATE_G3 = 2'b10
  } ssc_rate_e;

  // one dword with its control-character flags
  typedef struct packed {
    logic [3:0] k;
    logic [31:0] d;
  } ssc_dword_s;

  // partner description from the link reset sequence
  typedef struct packed {
    ssc_ptype_e ptype;
    logic ssc_cap;
  } ssc_partner_s;

endpackage

// [design/ssc_sweep.sv]
// ssc_sweep: symmetrical triangular modulation profile generator
// assumes a free running clk_i at the rate in ssc_consts.svh
`timescale 1ns/1ps
`include "ssc_consts.svh"

module ssc_sweep #(
  parameter int HALF = `SSC_HALF_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic run_i,
  // profile position, 0 at one extreme, HALF at the other
  output logic [11:0] phase_o
);

  logic [11:0] cnt_q;
  logic up_q;
  wire at_top = (cnt_q == 12'(HALF - 1));
  wire at_bot = (cnt_q == 12'h001);

  // rising half then its mirror image falling half
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !run_i)
    begin
      cnt_q <= 12'h000;
      up_q <= 1'b1;
    end
    else if (up_q)
    begin
      cnt_q <= cnt_q + 12'h001;
      up_q <= !at_top;
    end
    else
    begin
      cnt_q <= cnt_q - 12'h001;
      up_q <= at_bot;
    end
  end

  assign phase_o = cnt_q;

endmodule // ssc_sweep

// [design/ssc_tol_buf.sv]
// ssc_tol_buf: center-spreading tolerance buffer, a dword fifo
// assumes writer and reader share clk_i
`timescale 1ns/1ps
`include "ssc_consts.svh"

module ssc_tol_buf #(
  parameter int W = 36,
  parameter int DEPTH = `SSC_BUF_G3,
  parameter int AW = 6
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // fill side
  input wire logic wr_valid_i,
  input wire logic [W-1:0] wr_data_i,
  output logic wr_ready_o,
  // drain side
  output logic rd_valid_o,
  output logic [W-1:0] rd_data_o,
  input wire logic rd_ready_i,
  // fill level
  output logic [AW:0] count_o
);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;

  wire wr_go = wr_valid_i && wr_ready_o;
  wire rd_go = rd_valid_o && rd_ready_i;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  // storage
  always_ff @(posedge clk_i)
  begin
    if (wr_go)
      mem[wp_q] <= wr_data_i;
  end

  // pointers and level
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (wr_go)
        wp_q <= bump(wp_q);
      if (rd_go)
        rp_q <= bump(rp_q);
      cnt_q <= cnt_q + (AW+1)'(wr_go) - (AW+1)'(rd_go);
    end
  end

  assign wr_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign rd_valid_o = (cnt_q != '0);
  assign rd_data_o = mem[rp_q];
  assign count_o = cnt_q;

endmodule // ssc_tol_buf

// [testbench/ssc_chk_assertions.sv]
// ssc_chk: port-level assertions on the align link control
// assumes the design top ssc_align_ctrl, one clock domain on clk_i
`timescale 1ns/1ps
`include "ssc_consts.svh"

module ssc_chk
  import ssc_pkg::*;
#(
  parameter int HALF = `SSC_HALF_CYC,
  parameter int BUF_DEPTH = `SSC_BUF_G3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // link state and requests
  input wire logic oob_active_i,
  input wire logic snw_active_i,
  input wire logic final_snw_i,
  input wire logic reset_done_i,
  input wire logic align_req_i,
  input wire logic snw_align1_i,
  input wire ssc_pkg::ssc_dword_s rx_dword_i,
  // observed outputs
  input wire ssc_pkg::ssc_dword_s tx_dword_o,
  input wire logic tx_prim_o,
  input wire logic tx_clk_int_o,
  input wire ssc_pkg::ssc_mode_e ssc_mode_o,
  input wire logic ssc_en_o,
  input wire logic [13:0] ssc_ppm_o,
  input wire logic rx_align_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // link phase shorthands
  wire in_oob = oob_active_i;
  wire in_snw = snw_active_i && !oob_active_i && !reset_done_i;

  AST_TXCLK: assert property (tx_clk_int_o)
    else $error("transmit clock not from internal source");
  AST_OOB_A0: assert property (
    in_oob && $past(in_oob) && align_req_i
    |=> tx_prim_o && tx_dword_o.d == `SSC_ALIGN0)
    else $error("out-of-band align is not variant 0");
  AST_SNW_A01: assert property (
    in_snw && $past(in_snw) && align_req_i |=> tx_prim_o &&
    tx_dword_o.d == ($past(snw_align1_i) ? `SSC_ALIGN1 : `SSC_ALIGN0))
    else $error("negotiation align variant wrong");
  AST_NO_NOTIFY: assert property (
    (in_oob || in_snw) && $past(in_oob || in_snw)
    |=> !(tx_prim_o && tx_dword_o.d == `SSC_NOTIFY))
    else $error("notify sent during oob or negotiation");
  AST_EN_FINAL: assert property (
    final_snw_i && !in_oob && ssc_mode_o != SSC_MODE_NONE |=> ssc_en_o)
    else $error("spreading not enabled before final window");
  AST_EN_OFF: assert property (in_oob |=> !ssc_en_o)
    else $error("spreading still on after oob");
  AST_EN_HOLD: assert property (ssc_en_o && !in_oob |=> ssc_en_o)
    else $error("spreading dropped without oob");
  AST_MODE_HOLD: assert property (
    ssc_en_o && !in_oob |=> $stable(ssc_mode_o))
    else $error("mode changed while spreading");
  AST_CTR_RANGE: assert property (
    ssc_en_o && ssc_mode_o == SSC_MODE_CENTER
    |-> $signed(ssc_ppm_o) >= -2600 && $signed(ssc_ppm_o) <= 2600)
    else $error("center offset out of range");
  AST_RX_FULL: assert property (
    rx_align_o |-> rx_dword_i.k == `SSC_KMASK && rx_dword_i.d inside
    {`SSC_ALIGN0, `SSC_ALIGN1, `SSC_ALIGN2, `SSC_ALIGN3})
    else $error("align flagged on a non-align dword");
endmodule // ssc_chk

bind ssc_align_ctrl ssc_chk #(.HALF(HALF), .BUF_DEPTH(BUF_DEPTH)) u_chk (
  .clk_i, .rst_n_i, .oob_active_i, .snw_active_i, .final_snw_i,
  .reset_done_i, .align_req_i, .snw_align1_i, .rx_dword_i, .tx_dword_o,
  .tx_prim_o, .tx_clk_int_o, .ssc_mode_o, .ssc_en_o, .ssc_ppm_o,
  .rx_align_o);

// [testbench/ssc_far_phy.sv]
// ssc_far_phy: behavioural far-side phy driving the received stream
// assumes the bench queues dwords through send()
`timescale 1ns/1ps

module ssc_far_phy
  import ssc_pkg::*;
(
  // recovered clock and dword
  output logic rx_clk_o,
  output ssc_pkg::ssc_dword_s rx_dword_o
);
  ssc_dword_s q[$];

  // queue one dword for the line
  task automatic send(input ssc_dword_s dw);
    q.push_back(dw);
  endtask

  // free 160 ns line clock, new dword on each falling edge
  initial
  begin
    rx_clk_o = 1'b0;
    rx_dword_o = '0;
    #3.7;
    forever
    begin
      #80 rx_clk_o = ~rx_clk_o;
      if (!rx_clk_o)
        rx_dword_o = (q.size() > 0) ? q.pop_front() : {4'h0, $urandom()};
    end
  end
endmodule // ssc_far_phy

// [testbench/ssc_align_ctrl_test.sv]
// ssc_align_ctrl_test: self-checking bench for the align link control
// assumes ssc_far_phy as far side and the bound ssc_chk checker
`timescale 1ns/1ps
`include "ssc_consts.svh"

module ssc_align_ctrl_test;
  import ssc_pkg::*;
  localparam int H = 16;
  localparam logic [31:0] AL [4] = '{`SSC_ALIGN0, `SSC_ALIGN1,
    `SSC_ALIGN2, `SSC_ALIGN3};
  localparam logic [35:0] RXS [7] = '{{4'h1, `SSC_ALIGN2},
    {4'h1, `SSC_ALIGN0}, {4'h1, `SSC_NOTIFY}, {4'h1, `SSC_ALIGN3},
    {4'h1, 32'h4A4A4ABC}, {4'h0, `SSC_ALIGN1}, {4'h1, `SSC_ALIGN1}};
  localparam int EXPV [4] = '{2, 0, 3, 1};
  logic clk_i, rst_n_i, is_expander_i, ssc_cap_i, sata_cap_i;
  logic oob_active_i, snw_active_i, final_snw_i, reset_done_i;
  logic partner_valid_i, align_req_i, snw_align1_i, notify_req_i;
  logic rx_clk_i, fwd_ready_i, tx_sent_o, tx_prim_o, tx_clk_int_o;
  logic ssc_en_o, rx_align_o, buf_ovf_o, buf_low_o;
  logic [1:0] rx_align_var_o;
  logic [6:0] buf_level_o;
  logic [13:0] ssc_ppm_o;
  ssc_rate_e rate_i;
  ssc_partner_s partner_i;
  ssc_dword_s tx_dword_i, tx_dword_o, rx_dword_i;
  ssc_mode_e ssc_mode_o;
  int bad_count, n_checks, got_q[$];
  int dec;
  logic rx_valid_o, fwd_valid_o, run_seen;
  ssc_dword_s rx_dword_o, fwd_dword_o, fwd_q[$];

  ssc_align_ctrl #(.HALF(H)) dut (.clk_i, .rst_n_i, .is_expander_i,
    .ssc_cap_i, .sata_cap_i, .rate_i, .oob_active_i, .snw_active_i,
    .final_snw_i, .reset_done_i, .partner_valid_i, .partner_i,
    .align_req_i, .snw_align1_i, .notify_req_i, .tx_dword_i, .tx_dword_o,
    .tx_sent_o, .tx_prim_o, .tx_clk_int_o, .ssc_mode_o, .ssc_en_o,
    .ssc_ppm_o, .rx_clk_i, .rx_dword_i, .rx_align_o, .rx_align_var_o,
    .rx_valid_o, .rx_dword_o, .fwd_valid_o, .fwd_dword_o,
    .fwd_ready_i, .buf_level_o, .buf_ovf_o, .buf_low_o);
  ssc_far_phy u_far (.rx_clk_o(rx_clk_i), .rx_dword_o(rx_dword_i));

  // 100 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // collect received align variants
  always @(posedge clk_i)
  begin
    #1;
    if (rx_align_o === 1'b1)
      got_q.push_back(rx_align_var_o);
  end

  // run phase as the design saw it at the last edge
  always @(posedge clk_i)
    run_seen <= reset_done_i && !oob_active_i;

  // forward model: data received in run leaves the buffer in order
  always @(negedge clk_i)
  begin
    if (rx_valid_o === 1'b1 && run_seen)
      fwd_q.push_back(rx_dword_o);
    if (rx_valid_o === 1'b1 && rx_dword_o inside
      {{4'h1, 32'h4A4A4ABC}, {4'h0, `SSC_ALIGN1}})
      dec++;
    if (fwd_valid_o === 1'b1 && fwd_ready_i)
      chk(fwd_dword_o, (fwd_q.size() > 0) ? fwd_q.pop_front() : '1);
  end

  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    int rot, r, lo, hi, ok, pe, m, k, p, c;
    int s[4*H];
    ssc_dword_s d;
    void'($urandom(32'h5C919B17));
    {rst_n_i, is_expander_i, snw_active_i, final_snw_i} = '0;
    {reset_done_i, partner_valid_i, align_req_i} = '0;
    {snw_align1_i, notify_req_i} = '0;
    {ssc_cap_i, sata_cap_i, oob_active_i, fwd_ready_i} = 4'hF;
    rate_i = SSC_RATE_G3;
    partner_i = '0;
    tx_dword_i = '0;
    repeat (4) tick;
    rst_n_i = 1'b1;
    chk(tx_clk_int_o, 1);
    // out of band, then negotiation, notify asked for throughout
    align_req_i = 1'b1;
    notify_req_i = 1'b1;
    tick;
    chk(tx_dword_o, {4'h1, AL[0]});
    oob_active_i = 1'b0;
    snw_active_i = 1'b1;
    tick;
    for (int v = 0; v < 2; v++)
    begin
      snw_align1_i = v[0];
      tick;
      chk(tx_dword_o, {4'h1, AL[v]});
    end
    {align_req_i, notify_req_i} = 2'b00;
    // every role and partner kind except end device to sata, ends expander to capable sas
    partner_valid_i = 1'b1;
    for (int x = 0; x < 12; x++)
    begin
      p = 2 - (x / 2) % 3;
      c = x / 6;
      if (x % 2 == 0 && p == 2)
        continue;
      is_expander_i = x[0];
      partner_i = {2'(p), c[0]};
      m = (x % 2) ? ((p == 2) ? 1 : 2 * c) : c;
      repeat (2) tick;
      chk(ssc_mode_o, m);
    end
    final_snw_i = 1'b1;
    tick;
    chk(ssc_en_o, 1);
    {final_snw_i, snw_active_i, partner_valid_i} = 3'b000;
    reset_done_i = 1'b1;
    repeat (3) tick;
    // two sweep periods: range, repetition and mirror symmetry
    for (int i = 0; i < 4 * H; i++)
    begin
      s[i] = $signed(ssc_ppm_o);
      tick;
    end
    {lo, hi, ok, pe} = {32'd0, 32'd0, 32'd0, 32'd1};
    for (int i = 0; i < 2 * H; i++)
    begin
      lo = (s[i] < lo) ? s[i] : lo;
      hi = (s[i] > hi) ? s[i] : hi;
      pe = pe & (s[i] == s[i + 2 * H]);
      k = 1;
      for (int j = 1; j < H; j++)
        k = k & (s[(i + j) % (2 * H)] == s[(i - j + 2 * H) % (2 * H)]);
      ok = ok | k;
    end
    chk(pe, 1);
    chk(ok, 1);
    chk(hi - lo, 5200);
    // random mix of user dwords, aligns and notifies
    rot = 0;
    for (int i = 0; i < 16; i++)
    begin
      r = (i < 4) ? 1 : $urandom % 3;
      d = {4'h0, 32'($urandom)};
      align_req_i = (r != 0);
      notify_req_i = (r == 2);
      tx_dword_i = d;
      tick;
      chk(tx_dword_o, (r == 0) ? d : {4'h1, (r == 2) ? `SSC_NOTIFY :
        AL[rot]});
      chk(tx_prim_o, r != 0);
      chk(tx_sent_o, r == 0);
      rot = (r == 1) ? (rot + 1) % 4 : rot;
    end
    {align_req_i, notify_req_i} = 2'b00;
    // received aligns out of order with decoys, forwarding stalled
    fwd_ready_i = 1'b0;
    got_q.delete();
    dec = 0;
    foreach (RXS[i])
      u_far.send(RXS[i]);
    repeat (160) tick;
    chk(got_q.size(), 4);
    chk(dec, 2);
    foreach (EXPV[i])
      chk(got_q[i], EXPV[i]);
    chk(buf_level_o != 0, 1);
    fwd_ready_i = 1'b1;
    k = 0;
    while (buf_level_o !== 7'h00 && k < 100)
    begin
      tick;
      k++;
    end
    chk(k < 100, 1);
    if (k == 100)
      summarize;
    chk(buf_ovf_o, 0);
    for (int i = 0; i < 3; i++)
    begin
      rate_i = ssc_rate_e'(i);
      repeat (2) tick;
      chk(buf_low_o, 0);
    end
    // new out-of-band signal ends spreading
    oob_active_i = 1'b1;
    repeat (2) tick;
    chk(ssc_en_o, 0);
    chk(ssc_mode_o, SSC_MODE_NONE);
    summarize;
  end
endmodule // ssc_align_ctrl_test
